/* bench/linear_pixel_scan_sequencer_test.sv */
// Purpose: Self-checking bench for the scan sequencer
// Assumes: Controller model drives the pins
// Notes:   Monitor pops one note per change of pixel index
`timescale 1ns/1ps
`include "lps_consts.svh"
module linear_pixel_scan_sequencer_test;
   localparam int N = `LPS_PIXELS;
   logic                  clk, rst_b, sensorClk, scanStart, holdIn;
   logic [1:0]            halfExtra;
   logic                  pixelValid, analogPixelOutputEn;
   logic                  integratorResetSwitch, endOfScan;
   logic [`LPS_CNT_W-1:0] pixelIndex, lastIndex;
   logic [N-1:0]          sampleCapacitorHold;
   logic [31:0]           lfsrState;
   int                    expQ[$];
   int                    err_count, checks, cycles, kSeen;

   lps_sequencer #(.PIXELS(N)) u_lps_sequencer (.clk(clk), .rst_b(rst_b),
      .sensorClk(sensorClk), .scanStart(scanStart), .holdIn(holdIn),
      .pixelValid(pixelValid), .pixelIndex(pixelIndex),
      .analogPixelOutputEn(analogPixelOutputEn),
      .integratorResetSwitch(integratorResetSwitch),
      .sampleCapacitorHold(sampleCapacitorHold), .endOfScan(endOfScan));
   lps_scan_ctrl u_lps_scan_ctrl (.clk(clk), .halfExtra(halfExtra),
      .sensorClk(sensorClk), .scanStart(scanStart), .holdIn(holdIn));

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic cmp(input string name, input logic [N-1:0] exp,
                      input logic [N-1:0] got);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic results();
      $display("checks %0d err_count %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // Outputs expected after sensor clock edge k of a scan
   task automatic check_edge(input int k);
      logic [N-1:0] h;
      h = (k < `LPS_RELEASE_CLK) ? '1 : ({N{1'b1}} << (k - 1));
      cmp("index", N'((k > N) ? 0 : k), N'(pixelIndex));
      cmp("valid", N'(k <= N), N'(pixelValid));
      cmp("outEn", N'(k <= N), N'(analogPixelOutputEn));
      cmp("intReset", N'(k < 19), N'(integratorResetSwitch));
      cmp("hold", h, sampleCapacitorHold);
      cmp("endScan", N'(k > N), N'(endOfScan));
   endtask
   // Note expectations, then let the controller run the scan
   task automatic run_scan(input int edges, input bit settle);
      lfsrState = lfsr_next(lfsrState);
      halfExtra = lfsrState[1:0];
      for (int k = 1; k <= edges; k++) expQ.push_back(k);
      u_lps_scan_ctrl.scan(edges, settle);
   endtask

   // Clock
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // Monitor and timeout
   always @(negedge clk) begin
      cycles++;
      if (cycles > 60000) begin
         err_count++;
         results();
      end
      if (rst_b && pixelIndex !== lastIndex) begin
         if (expQ.size() == 0) cmp("spare", N'(0), N'(1));
         else begin
            kSeen = expQ.pop_front();
            check_edge(kSeen);
         end
      end
      lastIndex = pixelIndex;
   end
   // Main sequence
   initial begin
      rst_b = 1'b0;
      halfExtra = 2'h0;
      lastIndex = '0;
      lfsrState = 32'h6117;
      err_count = 0;
      checks = 0;
      cycles = 0;
      repeat (12) @(negedge clk);
      rst_b = 1'b1;
      cmp("resetIdx", N'(0), N'(pixelIndex));
      cmp("resetHold", N'(0), sampleCapacitorHold);
      run_scan(N + 1, 1'b1);
      run_scan(N + 1, 1'b1);
      // Random idle wait before the next start, far below 100 ms
      repeat (int'(lfsrState[9:2])) @(negedge clk);
      run_scan(N + 1, 1'b1);
      run_scan(N + 1, 1'b1);
      repeat (20) @(negedge clk);
      cmp("queueLeft", N'(0), N'(expQ.size()));
      results();
   end
endmodule

/* bench/lps_scan_ctrl.sv */
// Purpose: Scan controller model driving the sensor pins
// Assumes: Pins change on the falling system clock edge
// Notes:   Sensor clock is parked low between scans
`timescale 1ns/1ps
module lps_scan_ctrl #(
   parameter int WAIT_CLKS = 5000,
   // Half period floor keeps the sensor clock below 8 MHz
   parameter int HALF_MIN  = 16
) (
   input  wire logic       clk,
   input  wire logic [1:0] halfExtra,
   output logic            sensorClk,
   output logic            scanStart,
   output logic            holdIn
);
   // Hold pin shares the start signal on a single die
   assign holdIn = scanStart;
   // Idle levels
   initial begin
      sensorClk = 1'b0;
      scanStart = 1'b0;
   end
   // One scan: start with the first edge, then the remaining edges
   task automatic scan(input int edges, input bit settle);
      int h;
      h = HALF_MIN + int'(halfExtra);
      @(negedge clk) scanStart <= 1'b1;
      for (int k = 1; k <= edges; k++) begin
         repeat (h) @(negedge clk);
         sensorClk <= 1'b1;
         repeat (h) @(negedge clk);
         sensorClk <= 1'b0;
         scanStart <= 1'b0;
      end
      if (settle) repeat (WAIT_CLKS) @(negedge clk);
   endtask
endmodule

/* core/lps_sequencer.sv */
// Purpose: Scan and integration sequencing of a linear pixel array
// Assumes: Sensor clock, start and hold arrive as pins, sampled at 250 MHz
// Notes:   Analog switches are modelled as control bits, per pixel only for the sample holds
`timescale 1ns/1ps
`include "lps_consts.svh"
module lps_sequencer #(
   parameter int PIXELS = `LPS_PIXELS
) (
   input  wire logic                  clk,
   input  wire logic                  rst_b,
   input  wire logic                  sensorClk,
   input  wire logic                  scanStart,
   input  wire logic                  holdIn,
   output logic                       pixelValid,
   output logic [`LPS_CNT_W-1:0]      pixelIndex,
   output logic                       analogPixelOutputEn,
   output logic                       integratorResetSwitch,
   output logic [PIXELS-1:0]          sampleCapacitorHold,
   output logic                       endOfScan
);
   // ****************************************************
   // Input capture
   // ****************************************************
   logic                  sClkS;
   logic                  startS;
   logic                  holdS;
   logic                  sClkPrev_q;
   logic                  edgeRise;
   logic [`LPS_CNT_W-1:0] clkCnt_q;
   lps_pkg::lps_phase_t   phase_q;

   lps_sync #(.W(3)) uSync (
      .clk   (clk),
      .rst_b (rst_b),
      .din   ({sensorClk, scanStart, holdIn}),
      .dout  ({sClkS, startS, holdS})
   );

   // Rising edge detect on synchronised sensor clock
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sClkPrev_q <= 1'b0;
      end else begin
         sClkPrev_q <= sClkS;
      end
   end
   assign edgeRise = sClkS & ~sClkPrev_q;

   // Count sensor clocks since start; start counts as clock 1
   function automatic logic [`LPS_CNT_W-1:0] incSat(
      input logic [`LPS_CNT_W-1:0] v);
      incSat = (v == 8'hff) ? v : v + 8'h01;
   endfunction

   // ****************************************************
   // Sequencing
   // ****************************************************
   // Clock counter and phase
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         clkCnt_q <= 8'h00;
         phase_q  <= lps_pkg::LPS_IDLE;
      end else if (edgeRise) begin
         if (startS) begin
            clkCnt_q <= 8'h01;
            phase_q  <= lps_pkg::LPS_SETUP;
         end else if (phase_q != lps_pkg::LPS_IDLE) begin
            clkCnt_q <= incSat(clkCnt_q);
            if (clkCnt_q + 8'h01 == 8'(`LPS_RELEASE_CLK))
               phase_q <= lps_pkg::LPS_READOUT;
            else if (clkCnt_q + 8'h01 == 8'(PIXELS + 1))
               phase_q <= lps_pkg::LPS_IDLE;
         end
      end
   end

   // Integrator reset: from start through clock 18
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         integratorResetSwitch <= 1'b0;
      end else if (edgeRise) begin
         if (startS)
            integratorResetSwitch <= 1'b1;
         else if (clkCnt_q + 8'h01 == 8'(`LPS_RELEASE_CLK))
            integratorResetSwitch <= 1'b0;
      end
   end

   // Per-pixel sample hold: all frozen at start, released per slot
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sampleCapacitorHold <= '0;
      end else if (edgeRise) begin
         // Hold pin ends integration; tied to start on a single die
         if (startS || holdS) begin
            sampleCapacitorHold <= '1;
         end else begin
            for (int i = 0; i < PIXELS; i++) begin
               // Pixel i+1 resumes at clock max(19, i+2)
               if (clkCnt_q + 8'h01 == 8'(`LPS_RELEASE_CLK) &&
                   i < `LPS_SETUP_CLKS)
                  sampleCapacitorHold[i] <= 1'b0;
               else if (i >= `LPS_SETUP_CLKS &&
                        clkCnt_q + 8'h01 == 8'(i + 2))
                  sampleCapacitorHold[i] <= 1'b0;
            end
         end
      end
   end

   // Output slot: pixel k stands from clock k to clock k+1
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pixelValid          <= 1'b0;
         pixelIndex          <= 8'h00;
         analogPixelOutputEn <= 1'b0;
         endOfScan           <= 1'b0;
      end else begin
         endOfScan <= 1'b0;
         if (edgeRise) begin
            if (startS) begin
               pixelValid          <= 1'b1;
               pixelIndex          <= 8'h01;
               analogPixelOutputEn <= 1'b1;
            end else if (phase_q != lps_pkg::LPS_IDLE) begin
               if (clkCnt_q == 8'(PIXELS)) begin
                  pixelValid          <= 1'b0;
                  analogPixelOutputEn <= 1'b0;
                  pixelIndex          <= 8'h00;
                  endOfScan           <= 1'b1;
               end else begin
                  pixelIndex <= clkCnt_q + 8'h01;
               end
            end
         end
      end
   end

   // ****************************************************
   // Checks
   // ****************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   // Start pulse: freeze, first pixel, integrators in reset
   start_freeze_a: assert property (edgeRise && startS |=>
      sampleCapacitorHold == '1 && pixelIndex == 8'h01)
      else $error("start did not freeze pixels");
   reset_hold_a: assert property (edgeRise && startS |=>
      integratorResetSwitch)
      else $error("integrator reset not asserted");
   release_at19_a: assert property (edgeRise && !startS &&
      clkCnt_q == 8'd18 && phase_q == lps_pkg::LPS_SETUP |=>
      !integratorResetSwitch && phase_q == lps_pkg::LPS_READOUT)
      else $error("integrators not released at clock 19");
   setup_span_a: assert property (phase_q == lps_pkg::LPS_SETUP |->
      clkCnt_q <= 8'd18 && integratorResetSwitch)
      else $error("setup span wrong");
   // Pixel release after the setup clocks
   first_group_a: assert property (edgeRise && !startS &&
      clkCnt_q == 8'd18 |=> sampleCapacitorHold[17:0] == '0)
      else $error("first pixels not resumed");
   pixel19_a: assert property (edgeRise && !startS &&
      clkCnt_q == 8'd19 && phase_q == lps_pkg::LPS_READOUT |=>
      !sampleCapacitorHold[18])
      else $error("pixel 19 not resumed at clock 20");
   // Readout and scan end
   hiz_end_a: assert property (edgeRise && !startS &&
      clkCnt_q == 8'(PIXELS) |=> !analogPixelOutputEn && endOfScan
      && sampleCapacitorHold == '0)
      else $error("scan end wrong");
   slot_stable_a: assert property (!edgeRise |=>
      $stable(pixelIndex))
      else $error("pixel changed mid period");
   advance_a: assert property (edgeRise && !startS &&
      pixelValid && clkCnt_q < 8'(PIXELS) |=>
      pixelIndex == $past(pixelIndex) + 8'h01)
      else $error("pixel did not advance");
   // Hold pin, idle output and index range
   hold_freeze_a: assert property (edgeRise && holdS |=>
      sampleCapacitorHold == '1)
      else $error("hold did not freeze pixels");
   idle_off_a: assert property (phase_q == lps_pkg::LPS_IDLE |->
      !pixelValid && !analogPixelOutputEn && pixelIndex == 8'h00)
      else $error("output active while idle");
   end_pulse_a: assert property (endOfScan |=>
      !endOfScan)
      else $error("scan end pulse too long");
   index_range_a: assert property (pixelValid |->
      pixelIndex >= 8'h01 && pixelIndex <= 8'(PIXELS))
      else $error("pixel index out of range");
   readout_free_a: assert property (
      phase_q == lps_pkg::LPS_READOUT |-> !integratorResetSwitch)
      else $error("integrators reset during readout");

   // Main scenario coverage
   scan_start_c: cover property (edgeRise && startS);
   release_c: cover property ($fell(integratorResetSwitch));
   scan_end_c: cover property (endOfScan);
   last_pixel_c: cover property (pixelIndex == 8'(PIXELS));
endmodule

/* core/lps_sync.sv */
// Purpose: Two flip-flop synchroniser for pin inputs
// Assumes: Asynchronous active-low reset
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
module lps_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst_b,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] meta_q;

   // Two stage capture
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         meta_q <= '0;
         dout   <= '0;
      end else begin
         meta_q <= din;
         dout   <= meta_q;
      end
   end
endmodule

/* shared/lps_consts.svh */
// Purpose: Constants for the linear pixel scan sequencer
// Assumes: One system clock at 250 MHz
// Notes:   Counts are in sensor clock edges unless named otherwise
`ifndef LPS_CONSTS_SVH
`define LPS_CONSTS_SVH
`define LPS_PIXELS        128
`define LPS_SETUP_CLKS    18
`define LPS_RESET_CLKS    17
`define LPS_RELEASE_CLK   19
`define LPS_CNT_W         8
`endif

/* shared/lps_pkg.sv */
// Purpose: Types for the linear pixel scan sequencer
// Assumes: Nothing beyond the constants header
// Notes:   Phase of the scan cycle
package lps_pkg;
   typedef enum logic [1:0] {
      LPS_IDLE,
      LPS_SETUP,
      LPS_READOUT
   } lps_phase_t;
endpackage
